// file: hb_pkg.sv
// shared constants and types for the half-bridge pwm mapping block
package hb_pkg;
   localparam int NUM_BRIDGES = 4;
   localparam int NUM_CHANNELS = 3;
   localparam int CCP_WIDTH = 8;

   // clock rate and command latency bound
   localparam int CLK_HZ = 20_000_000;
   localparam int CMD_LATENCY_NS = 3000;
   localparam int CMD_LATENCY_CYCLES = (CMD_LATENCY_NS * (CLK_HZ / 1_000_000)) / 1000;

   // drive select encodings
   localparam logic [1:0] DRIVE_OFF = 2'h0;
   localparam logic [1:0] DRIVE_LOW = 2'h1;
   localparam logic [1:0] DRIVE_HIGH = 2'h2;
   localparam logic [1:0] DRIVE_OFF_ALT = 2'h3;

   // bridge select uses only the low two bits of three
   localparam int BSEL_LSB = 0;
   localparam int BSEL_MSB = 1;

   // gate drive current classes
   typedef enum logic [1:0] {
      GATE_HOLD = 2'b00,
      GATE_STATIC = 2'b01,
      GATE_HARDOFF = 2'b10
   } gate_current_t;

   typedef struct packed {
      logic [NUM_BRIDGES-1:0][1:0] bridge_drive_select;
   } bridge_drive_config_t;

   typedef struct packed {
      logic [NUM_CHANNELS-1:0] pwm_channel_enable;
      logic [NUM_CHANNELS-1:0][2:0] pwm_bridge_select;
   } pwm_routing_config_t;

   typedef struct packed {
      logic on;
      gate_current_t current;
   } gate_cmd_t;

   function automatic logic drive_is_off(input logic [1:0] sel);
      drive_is_off = (sel == DRIVE_OFF) || (sel == DRIVE_OFF_ALT);
   endfunction : drive_is_off
endpackage : hb_pkg

// file: bit_sync.sv
// two-flop synchroniser for a bus of independent level signals
`timescale 1ns/1ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // ==========================================================
   // capture stages
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : bit_sync

// file: ccp_timer.sv
// cross-conduction down-counter for one bridge
`timescale 1ns/1ps
module ccp_timer #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   output logic busy,
   output logic done
);
   logic [WIDTH-1:0] count_reg;

   // ==========================================================
   // counter
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         count_reg <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else if (load)
      begin
         // zero load still gives one cycle of protection
         count_reg <= (load_value == '0) ? WIDTH'(1) : load_value;
         busy <= 1'b1;
         done <= 1'b0;
      end
      else if (busy)
      begin
         count_reg <= count_reg - WIDTH'(1);
         done <= (count_reg == WIDTH'(1));
         busy <= (count_reg != WIDTH'(1));
      end
      else
      begin
         done <= 1'b0;
      end
   end
endmodule : ccp_timer

// file: hb_pwm_map.sv
// pwm routing, both-off sequencing and freewheel control for four half-bridges
//
// Functional notes
// - drive select 00 or 11 discharges both gates statically for active ccp time
// - after active ccp time of both-off, both gates go to hold current
// - chip select rise synchronised; command applied within 3 us
// - three pwm channels, each from its own input pin
// - cleared channel enable means no pwm from that channel anywhere
// - bridge select decodes low two bits; top bit ignored
// - selected bridge in 00 or 11 gets no pwm
// - enabled channel drives low side on 01, high side on 10
// - bridge chosen by several enabled channels: error, both off, conflict flag
// - in pwm mode freewheel mosfet turns on whenever active mosfet is off and the ccp timer is not running
// - generator detect off: pwm mosfet is active, opposite freewheels
// - generator detect on: comparators sampled at end of each ccp time
// - switch node above upper threshold: high freewheels, low active
// - switch node below lower threshold: low freewheels, high active
// - switch node between thresholds: mosfet about to turn on is active
// - pwm routed by drive select regardless of active/freewheel decision
// - phase shorter than its ccp time: pwm mosfet treated as active
// - unmapped bridge statically turns on low side on 01, high on 10
`timescale 1ns/1ps
module hb_pwm_map
   import hb_pkg::*;
#(
   parameter int NB = hb_pkg::NUM_BRIDGES,
   parameter int NC = hb_pkg::NUM_CHANNELS,
   parameter int CW = hb_pkg::CCP_WIDTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic chip_select_low,
   input wire hb_pkg::bridge_drive_config_t bridge_drive_config_reg,
   input wire hb_pkg::pwm_routing_config_t pwm_routing_config_reg,
   input wire logic generator_detect_enable,
   input wire logic [NC-1:0] pwm_in,
   input wire logic [NB-1:0] switch_node_above_upper,
   input wire logic [NB-1:0] switch_node_below_lower,
   input wire logic [NB*CW-1:0] active_ccp_time,
   input wire logic [NB*CW-1:0] freewheel_crossconduction_time,
   output hb_pkg::gate_cmd_t [NB-1:0] high_side_switch,
   output hb_pkg::gate_cmd_t [NB-1:0] low_side_switch,
   output logic [NB-1:0] pwm_map_conflict_flag,
   output logic [NB-1:0] high_side_active,
   output logic spi_error
);
   import hb_pkg::*;

   // ==========================================================
   // synchronisers
   logic cs_sync;
   logic cs_prev_reg;
   logic cmd_apply;
   logic cfg_fresh_reg;
   logic [NC-1:0] pwm_sync;
   logic [NB-1:0] above_sync;
   logic [NB-1:0] below_sync;

   bit_sync #(.WIDTH(1)) u_cs_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(chip_select_low),
      .sync_out(cs_sync)
   );

   bit_sync #(.WIDTH(NC)) u_pwm_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(pwm_in),
      .sync_out(pwm_sync)
   );

   bit_sync #(.WIDTH(2*NB)) u_cmp_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in({switch_node_above_upper, switch_node_below_lower}),
      .sync_out({above_sync, below_sync})
   );

   // ==========================================================
   // command capture on chip select release
   bridge_drive_config_t drive_cfg_reg;
   pwm_routing_config_t route_cfg_reg;
   logic gen_en_reg;

   // settings only take effect at the end of a frame, so half-written
   // configuration is never seen by the gate logic
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cs_prev_reg <= 1'b1;
         cmd_apply <= 1'b0;
         cfg_fresh_reg <= 1'b0;
      end
      else
      begin
         cs_prev_reg <= cs_sync;
         cmd_apply <= cs_sync && !cs_prev_reg;
         // captured settings are only visible one cycle after the apply strobe
         cfg_fresh_reg <= cmd_apply;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         drive_cfg_reg <= '0;
         route_cfg_reg <= '0;
         gen_en_reg <= 1'b0;
      end
      else if (cmd_apply)
      begin
         drive_cfg_reg <= bridge_drive_config_reg;
         route_cfg_reg <= pwm_routing_config_reg;
         gen_en_reg <= generator_detect_enable;
      end
   end

   // ==========================================================
   // channel to bridge mapping
   function automatic logic [NB-1:0] bridge_onehot(input logic [2:0] sel);
      logic [NB-1:0] v;
      v = '0;
      v[sel[BSEL_MSB:BSEL_LSB]] = 1'b1;
      bridge_onehot = v;
   endfunction : bridge_onehot

   logic [NB-1:0] map_count_many;
   logic [NB-1:0] mapped;
   logic [NB-1:0] bridge_pwm;

   always_comb
   begin
      logic [NB-1:0] hit;
      logic [NB-1:0] seen;
      logic [NB-1:0] many;
      logic [NB-1:0] pw;
      hit = '0;
      seen = '0;
      many = '0;
      pw = '0;
      for (int c = 0; c < NC; c++)
      begin
         hit = route_cfg_reg.pwm_channel_enable[c] ?
               bridge_onehot(route_cfg_reg.pwm_bridge_select[c]) : '0;
         many = many | (seen & hit);
         seen = seen | hit;
         for (int b = 0; b < NB; b++)
         begin
            if (hit[b])
            begin
               pw[b] = pwm_sync[c];
            end
         end
      end
      map_count_many = many;
      mapped = seen;
      bridge_pwm = pw;
   end

   // ==========================================================
   // per-bridge sequencing
   logic [NB-1:0] off_seq_reg;
   logic [NB-1:0] pwm_prev_reg;
   logic [NB-1:0] lead_reg;
   logic [NB-1:0] timer_load;
   logic [NB-1:0] timer_busy;
   logic [NB-1:0] timer_done;
   logic [NB*CW-1:0] timer_value;
   logic [NB-1:0] was_off_reg;

   genvar gb;
   generate
      for (gb = 0; gb < NB; gb++)
      begin : g_bridge
         logic [1:0] sel;
         logic off_mode;
         logic pwm_mode;
         logic conflict;
         logic pwm_hs;
         logic pwm_on;
         logic edge_now;
         logic pwm_mosfet_on_next;

         assign sel = drive_cfg_reg.bridge_drive_select[gb];
         assign off_mode = drive_is_off(sel);
         assign conflict = map_count_many[gb];
         assign pwm_mode = mapped[gb] && !off_mode && !conflict;
         assign pwm_hs = (sel == DRIVE_HIGH);
         assign pwm_on = bridge_pwm[gb];
         assign edge_now = pwm_mode && (pwm_on != pwm_prev_reg[gb]);
         // the mosfet that the pending edge turns on
         assign pwm_mosfet_on_next = pwm_on;

         // load active time on entering off or on a pwm-mosfet turn-on edge,
         // freewheel time when the pwm mosfet turns off
         assign timer_load[gb] = (off_mode && !was_off_reg[gb] && cfg_fresh_reg) || edge_now;
         assign timer_value[gb*CW +: CW] =
            (edge_now && !pwm_on) ? freewheel_crossconduction_time[gb*CW +: CW]
                                  : active_ccp_time[gb*CW +: CW];

         ccp_timer #(.WIDTH(CW)) u_ccp (
            .clk(clk),
            .rst_n(rst_n),
            .load(timer_load[gb]),
            .load_value(timer_value[gb*CW +: CW]),
            .busy(timer_busy[gb]),
            .done(timer_done[gb])
         );

         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               was_off_reg[gb] <= 1'b1;
               off_seq_reg[gb] <= 1'b0;
               pwm_prev_reg[gb] <= 1'b0;
            end
            else
            begin
               if (cfg_fresh_reg)
               begin
                  was_off_reg[gb] <= off_mode;
               end
               if (timer_load[gb] && off_mode)
               begin
                  off_seq_reg[gb] <= 1'b1;
               end
               else if (timer_done[gb] || !off_mode)
               begin
                  off_seq_reg[gb] <= 1'b0;
               end
               pwm_prev_reg[gb] <= pwm_on;
            end
         end

         // active mosfet decision
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               lead_reg[gb] <= 1'b0;
            end
            else if (!gen_en_reg || !pwm_mode)
            begin
               lead_reg[gb] <= pwm_hs;
            end
            else if (edge_now && timer_busy[gb])
            begin
               // phase shorter than ccp: no valid sample
               lead_reg[gb] <= pwm_hs;
            end
            else if (timer_done[gb])
            begin
               if (above_sync[gb])
               begin
                  lead_reg[gb] <= 1'b0;
               end
               else if (below_sync[gb])
               begin
                  lead_reg[gb] <= 1'b1;
               end
               else
               begin
                  // about to turn on: pwm mosfet when pwm high, else opposite
                  lead_reg[gb] <= pwm_mosfet_on_next ? pwm_hs : !pwm_hs;
               end
            end
         end

         // gate outputs
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               high_side_switch[gb] <= '{on: 1'b0, current: GATE_HOLD};
               low_side_switch[gb] <= '{on: 1'b0, current: GATE_HOLD};
            end
            else if (conflict)
            begin
               high_side_switch[gb] <= '{on: 1'b0, current: GATE_STATIC};
               low_side_switch[gb] <= '{on: 1'b0, current: GATE_STATIC};
            end
            else if (off_mode)
            begin
               high_side_switch[gb] <= '{on: 1'b0,
                  current: ((off_seq_reg[gb] || !was_off_reg[gb]) ? GATE_STATIC : GATE_HOLD)};
               low_side_switch[gb] <= '{on: 1'b0,
                  current: ((off_seq_reg[gb] || !was_off_reg[gb]) ? GATE_STATIC : GATE_HOLD)};
            end
            else if (pwm_mode)
            begin
               // both held off while the ccp timer runs; freewheel fills the gap
               high_side_switch[gb] <= '{on: (!timer_busy[gb] &&
                  (pwm_hs ? pwm_on : !pwm_on)), current: GATE_HOLD};
               low_side_switch[gb] <= '{on: (!timer_busy[gb] &&
                  (pwm_hs ? !pwm_on : pwm_on)), current: GATE_HOLD};
            end
            else
            begin
               high_side_switch[gb] <= '{on: (sel == DRIVE_HIGH), current: GATE_HOLD};
               low_side_switch[gb] <= '{on: (sel == DRIVE_LOW), current: GATE_HOLD};
            end
         end
      end
   endgenerate

   // ==========================================================
   // status
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pwm_map_conflict_flag <= '0;
         high_side_active <= '0;
         spi_error <= 1'b0;
      end
      else
      begin
         pwm_map_conflict_flag <= map_count_many;
         high_side_active <= lead_reg;
         spi_error <= |map_count_many;
      end
   end
endmodule : hb_pwm_map

// file: hb_pwm_map_assertions.sv
// concurrent checks on the pwm mapping block ports
`timescale 1ns/1ps
module hb_pwm_map_assertions
   import hb_pkg::*;
#(
   parameter int NB = 4,
   parameter int NC = 3,
   parameter int CW = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic chip_select_low,
   input wire hb_pkg::bridge_drive_config_t bridge_drive_config_reg,
   input wire hb_pkg::pwm_routing_config_t pwm_routing_config_reg,
   input wire hb_pkg::gate_cmd_t [NB-1:0] high_side_switch,
   input wire hb_pkg::gate_cmd_t [NB-1:0] low_side_switch,
   input wire logic [NB-1:0] pwm_map_conflict_flag,
   input wire logic spi_error
);
   logic [NB-1:0] hs_on;
   logic [NB-1:0] ls_on;
   logic [NB-1:0] off_mask;
   logic [NB-1:0] conf_mask;
   logic [NB-1:0] st_mask;
   // ====================
   // per-bridge views
   always_comb
   begin
      int n;
      n = 0;
      for (int b = 0; b < NB; b++)
      begin
         n = 0;
         for (int c = 0; c < NC; c++)
            n += int'(pwm_routing_config_reg.pwm_channel_enable[c]
               && pwm_routing_config_reg.pwm_bridge_select[c][1:0] == 2'(b));
         conf_mask[b] = n > 1;
         hs_on[b] = high_side_switch[b].on;
         ls_on[b] = low_side_switch[b].on;
         // 00 and 11 both mean off
         off_mask[b] = !(^bridge_drive_config_reg.bridge_drive_select[b]);
         st_mask[b] = off_mask[b] && !pwm_map_conflict_flag[b] && !hs_on[b]
            && high_side_switch[b].current == GATE_STATIC;
      end
   end
   // ====================
   // properties
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence cs_rise;
      $rose(chip_select_low);
   endsequence
   sequence off_done;
      ((hs_on | ls_on) & off_mask) == '0;
   endsequence
   off_cmd_a: assert property (cs_rise |-> ##[1:60] off_done)
      else $error("bridge set off still driven");
   no_overlap_a: assert property ((hs_on & ls_on) == '0)
      else $error("both switches of a bridge on");
   error_flag_a: assert property (|pwm_map_conflict_flag |-> ##[0:1] spi_error)
      else $error("conflict without error");
   error_clear_a: assert property ((!(|pwm_map_conflict_flag)) [*2] |-> !spi_error)
      else $error("error without conflict");
   conflict_off_a: assert property ($stable(pwm_map_conflict_flag) |->
      (pwm_map_conflict_flag & (hs_on | ls_on)) == '0)
      else $error("conflicting bridge driven");
   conflict_map_a: assert property ((chip_select_low && $stable(pwm_routing_config_reg)) [*8]
      |-> pwm_map_conflict_flag == conf_mask)
      else $error("conflict flags wrong");
   reset_off_a: assert property (disable iff (1'b0)
      !rst_n |=> (hs_on | ls_on | pwm_map_conflict_flag) == '0)
      else $error("outputs not cleared by reset");
   for (genvar b = 0; b < NB; b++)
   begin : g_br
      hold_after_a: assert property (st_mask[b] |-> ##[1:260]
         (high_side_switch[b].current == GATE_HOLD || !off_mask[b] || pwm_map_conflict_flag[b]))
         else $error("off bridge never reached hold");
   end
endmodule : hb_pwm_map_assertions
bind hb_pwm_map hb_pwm_map_assertions #(.NB(NB), .NC(NC), .CW(CW)) chk (.clk(clk),
   .rst_n(rst_n), .chip_select_low(chip_select_low),
   .bridge_drive_config_reg(bridge_drive_config_reg),
   .pwm_routing_config_reg(pwm_routing_config_reg), .high_side_switch(high_side_switch),
   .low_side_switch(low_side_switch), .pwm_map_conflict_flag(pwm_map_conflict_flag),
   .spi_error(spi_error));

// file: host_model.sv
// host model driving command frames and pwm pins
`timescale 1ns/1ps
module host_model
   import hb_pkg::*;
(
   input wire logic clk,
   output logic chip_select_low,
   output hb_pkg::bridge_drive_config_t drive_cfg,
   output hb_pkg::pwm_routing_config_t route_cfg,
   output logic gen_det,
   output logic [NUM_CHANNELS-1:0] pwm_in
);
   // ====================
   // frames
   initial
   begin
      chip_select_low = 1'b1;
      drive_cfg = '0;
      route_cfg = '0;
      gen_det = 1'b0;
      pwm_in = '0;
   end
   // settings move only while selected, so each rise latches a whole frame
   task automatic send(input bridge_drive_config_t d, input pwm_routing_config_t r,
      input logic g, input int n);
      @(posedge clk);
      chip_select_low <= 1'b0;
      drive_cfg <= d;
      route_cfg <= r;
      gen_det <= g;
      repeat (4) @(posedge clk);
      chip_select_low <= 1'b1;
      repeat (n) @(posedge clk);
   endtask : send
   task automatic start_pwm(input int b, input int c, input logic [1:0] m, input logic top);
      bridge_drive_config_t d;
      pwm_routing_config_t r;
      d = drive_cfg;
      r = route_cfg;
      d.bridge_drive_select[b] = DRIVE_OFF;
      send(d, r, gen_det, 8);
      r.pwm_channel_enable[c] = 1'b1;
      r.pwm_bridge_select[c] = {top, 2'(b)};
      send(d, r, gen_det, 8);
      d.bridge_drive_select[b] = m;
      send(d, r, gen_det, 8);
   endtask : start_pwm
endmodule : host_model

// file: testbench.sv
// self-checking bench for the pwm mapping block
`timescale 1ns/1ps
`define CHK(n, e, a) \
   begin \
      checked++; \
      if ((a) !== (e)) \
      begin \
         fails++; \
         $display("[ERR] %s exp %h got %h", n, e, a); \
      end \
   end
module testbench;
   import hb_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] above = '0;
   logic [3:0] below = '0;
   logic [31:0] ccp_act = {4{8'h08}};
   logic [31:0] ccp_fw = {4{8'h02}};
   logic cs;
   bridge_drive_config_t dcfg;
   pwm_routing_config_t rcfg;
   logic gde;
   logic [2:0] pwm;
   gate_cmd_t [3:0] hs;
   gate_cmd_t [3:0] ls;
   logic [3:0] flag;
   logic [3:0] hsa;
   logic err;
   int fails = 0;
   int checked = 0;
   always #25 clk = ~clk;
   host_model host (.clk(clk), .chip_select_low(cs), .drive_cfg(dcfg), .route_cfg(rcfg),
      .gen_det(gde), .pwm_in(pwm));
   hb_pwm_map dut (.clk(clk), .rst_n(rst_n), .chip_select_low(cs),
      .bridge_drive_config_reg(dcfg), .pwm_routing_config_reg(rcfg),
      .generator_detect_enable(gde), .pwm_in(pwm), .switch_node_above_upper(above),
      .switch_node_below_lower(below), .active_ccp_time(ccp_act),
      .freewheel_crossconduction_time(ccp_fw), .high_side_switch(hs), .low_side_switch(ls),
      .pwm_map_conflict_flag(flag), .high_side_active(hsa), .spi_error(err));
   // ====================
   // expectations
   // {conflict, high on, low on} once every timer has run out
   function automatic logic [11:0] expect_on(bridge_drive_config_t d, pwm_routing_config_t r,
      logic [2:0] p);
      int n;
      int ch;
      logic pw;
      expect_on = '0;
      for (int b = 0; b < 4; b++)
      begin
         n = 0;
         ch = 0;
         for (int c = 0; c < 3; c++)
            if (r.pwm_channel_enable[c] && r.pwm_bridge_select[c][1:0] == 2'(b))
            begin
               n++;
               ch = c;
            end
         pw = (n == 0) || p[ch];
         expect_on[8 + b] = n > 1;
         if (n < 2 && d.bridge_drive_select[b] == DRIVE_LOW)
         begin
            expect_on[b] = pw;
            expect_on[4 + b] = !pw;
         end
         if (n < 2 && d.bridge_drive_select[b] == DRIVE_HIGH)
         begin
            expect_on[4 + b] = pw;
            expect_on[b] = !pw;
         end
      end
   endfunction : expect_on
   task automatic settle(input logic [2:0] p);
      logic [11:0] e;
      logic [3:0] hv;
      logic [3:0] lv;
      @(posedge clk);
      host.pwm_in <= p;
      repeat (30) @(posedge clk);
      #1;
      e = expect_on(dcfg, rcfg, pwm);
      for (int b = 0; b < 4; b++)
      begin
         hv[b] = hs[b].on;
         lv[b] = ls[b].on;
         if (!(^dcfg.bridge_drive_select[b]) && !e[8 + b])
            `CHK("off current", GATE_HOLD, hs[b].current)
      end
      `CHK("high on", e[7:4], hv)
      `CHK("low on", e[3:0], lv)
      `CHK("conflict", e[11:8], flag)
      `CHK("spi error", |e[11:8], err)
   endtask : settle
   task automatic final_report();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // ====================
   // scenarios
   initial
   begin
      #2_000_000;
      fails++;
      final_report();
   end
   initial
   begin
      void'($urandom(13));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      settle(3'h0);
      host.start_pwm(2, 1, DRIVE_LOW, 1'b1);
      settle(3'h2);
      `CHK("high active", 1'b0, hsa[2])
      settle(3'h0);
      host.start_pwm(2, 1, DRIVE_HIGH, 1'b0);
      settle(3'h2);
      `CHK("high active", 1'b1, hsa[2])
      // first two frames: every channel on one bridge, then the same with all disabled
      for (int i = 0; i < 24; i++)
      begin
         host.send(bridge_drive_config_t'(8'($urandom)), pwm_routing_config_t'(i == 0 ?
            12'hefb : i == 1 ? 12'h0fb : 12'($urandom)), 1'b0, 4);
         settle(3'($urandom));
      end
      host.send(bridge_drive_config_t'(8'h01), '0, 1'b0, 20);
      host.send('0, '0, 1'b0, 7);
      #1;
      `CHK("static high", GATE_STATIC, hs[0].current)
      `CHK("static low", GATE_STATIC, ls[0].current)
      repeat (12) @(posedge clk);
      #1;
      `CHK("hold low", GATE_HOLD, ls[0].current)
      ccp_act <= {4{8'h02}};
      host.send('0, '0, 1'b1, 8);
      host.start_pwm(0, 0, DRIVE_HIGH, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         above <= {3'h0, k == 0};
         below <= {3'h0, k == 1};
         repeat (8)
         begin
            host.pwm_in[0] <= ~host.pwm_in[0];
            repeat (4) @(posedge clk);
         end
         host.pwm_in[0] <= k[0];
         repeat (10) @(posedge clk);
         host.pwm_in[0] <= !k[0];
         repeat (10) @(posedge clk);
         #1;
         `CHK("active side", 1'(k == 1 || k == 2), hsa[0])
         `CHK("pwm on high", !k[0], hs[0].on)
      end
      final_report();
   end
endmodule : testbench
